/* File: verilog/rtc_params.svh */
// Offsets, field positions, reset values and counts of the clock calendar
// Behaviour
// - Seconds, minutes keep bit 7 zero; BCD 00-59, binary 00-3B; reset 00h.
// - Seconds, minutes alarms share the live layout and ranges; reset zero.
// - 12-hour: bit 7 meridiem, bit 6 zero; BCD 1-12, binary 01-0C/81-8C.
// - 24-hour: bits 7:6 zero; BCD 00-23, binary 00-17; reset 12h.
// - Hours alarm follows the selected hour format, same layout and reset.
// - Weekday counts 1-7, Sunday is one, resets to seven.
// - Day of month spans 1-31, resets to one.
// - Month spans 1-12 resetting to one; year spans 0-99 resetting to zero.
// - Main control resets 00h: stop, coding, format, DST, enables, owner.
// - Status: alarm, osc fail, clock, clock irq flags; battery level.
// - Crystal config: invert, trim mode, low jitter, drive, load cap; 02h.
// - Clock source config: external clock select in bit 7, reset zero.
// - Timestamp registers 15h-1Bh mirror live time layouts and resets.
// - Addresses 1Eh through FFh are reserved and read zero.
// - Revision register: major in upper nibble, minor in lower, read-only.
// - Pointer advances after each data byte and wraps FFh to 00h.
// - Reads see a frozen time snapshot while counters keep running.
// - February gets a 29th day when the year divides by four.
// - Bank answers on its own seven-bit target address 1101 111.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_I2C_ADDR 7'h6F
`define RTC_TICKS_PER_SEC 32768
`define RTC_A_SEC 8'h00
`define RTC_A_SALM 8'h01
`define RTC_A_MIN 8'h02
`define RTC_A_MALM 8'h03
`define RTC_A_HOUR 8'h04
`define RTC_A_HALM 8'h05
`define RTC_A_WDAY 8'h06
`define RTC_A_MDAY 8'h07
`define RTC_A_MON 8'h08
`define RTC_A_YEAR 8'h09
`define RTC_A_CTRL 8'h0A
`define RTC_A_STAT 8'h0B
`define RTC_A_CLKO 8'h0C
`define RTC_A_CTRL2 8'h0D
`define RTC_A_SCR 8'h0E
`define RTC_A_REV 8'h0F
`define RTC_A_MAKER 8'h10
`define RTC_A_PART 8'h11
`define RTC_A_TRIM 8'h12
`define RTC_A_OSC 8'h13
`define RTC_A_SRC 8'h14
`define RTC_A_TS_SEC 8'h15
`define RTC_A_TS_MIN 8'h16
`define RTC_A_TS_HOUR 8'h17
`define RTC_A_TS_WDAY 8'h18
`define RTC_A_TS_MDAY 8'h19
`define RTC_A_TS_MON 8'h1A
`define RTC_A_TS_YEAR 8'h1B
`define RTC_A_RND1 8'h1C
`define RTC_A_RND2 8'h1D
`define RTC_B_STOP 7
`define RTC_B_BINARY 6
`define RTC_B_H12 5
`define RTC_B_AL_EN 3
`define RTC_B_OSCF_EN 2
`define RTC_B_CLK_EN 1
`define RTC_M_OSC 8'hDF
`define RTC_M_CLKO 8'h83
`define RTC_M_SRC 8'h80
`define RTC_M_CTRL2 8'h01
// Internal hour is binary 24-hour; 12 decimal reads back as 12h in BCD
`define RTC_R_HOUR 8'h0C
`define RTC_R_WDAY 8'h07
`define RTC_R_MDAY 8'h01
`define RTC_R_MON 8'h01
`define RTC_R_OSC 8'h02
`endif

/* File: verilog/rtc_pkg.sv */
// Types of the clock calendar register bank
package rtc_pkg;
  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0,
    I2C_ADDR = 4'h1,
    I2C_ACK_A = 4'h2,
    I2C_PTR = 4'h3,
    I2C_ACK_P = 4'h4,
    I2C_WR = 4'h5,
    I2C_ACK_W = 4'h6,
    I2C_RD = 4'h7,
    I2C_ACK_R = 4'h8
  } rtc_i2c_type;

  // Time held in plain binary, hour always 0-23
  typedef struct packed {
    logic [7:0] sec, min, hour, wday, mday, mon, year;
  } rtc_time_type;

  typedef struct packed {
    rtc_i2c_type st;
    logic scl_p, sda_p, rw, sda_oe;
    logic [3:0] bitc;
    logic [7:0] shreg, ptr;
    rtc_time_type tm, snap, stamp;
    logic [7:0] alm_sec, alm_min, alm_hour;
    logic [7:0] ctrl, clkctl, ctrl2, scratch, trim, osc, srccfg;
    logic [7:0] rnd1, rnd2;
    logic alarm_flag, osc_fail_flag, clock_flag, clock_irq_flag;
    logic [15:0] lfsr;
    logic [14:0] presc;
    logic alert, clkpin;
  } rtc_state_type;
endpackage

/* File: verilog/rtc_top.sv */
// Clock calendar register bank behind an I2C target port
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_top #(
  parameter int TICKS_PER_SEC = `RTC_TICKS_PER_SEC,
  // Identification values are arbitrary
  parameter logic [7:0] REVISION = 8'h21,
  parameter logic [7:0] MAKER = 8'hA5,
  parameter logic [7:0] PART = 8'h3C
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick_32k,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic osc_fail,
  input wire logic [2:0] battery_level,
  output logic alert_out,
  output logic alert_oe,
  output logic clock_output_pin
);
  generate
    if (TICKS_PER_SEC < 2 || TICKS_PER_SEC > 32768)
    begin : g_bad
      $error("TICKS_PER_SEC must lie in 2..32768");
    end
  endgenerate

  localparam logic [14:0] PRESC_LAST = 15'(TICKS_PER_SEC - 1);

  function automatic logic [7:0] enc(input logic [7:0] v, input logic bin);
    logic [7:0] t;
    logic [7:0] u;
    t = v / 8'h0A;
    u = v % 8'h0A;
    enc = bin ? v : {t[3:0], u[3:0]};
  endfunction

  function automatic logic [7:0] dec(input logic [7:0] v, input logic bin);
    dec = bin ? v : 8'h0A * {4'h0, v[7:4]} + {4'h0, v[3:0]};
  endfunction

  function automatic logic [7:0] hour_out(input logic [7:0] h,
    input logic bin, input logic h12);
    logic [7:0] hh;
    logic [7:0] e;
    logic pm;
    pm = h >= 8'h0C;
    hh = pm ? h - 8'h0C : h;
    if (hh == 8'h00)
    begin
      hh = 8'h0C;
    end
    e = enc(h12 ? hh : h, bin);
    hour_out = h12 ? {pm, 1'b0, e[5:0]} : {2'b00, e[5:0]};
  endfunction

  function automatic logic [7:0] hour_in(input logic [7:0] b,
    input logic bin, input logic h12);
    logic [7:0] hh;
    hh = dec({2'b00, b[5:0]}, bin);
    if (h12)
    begin
      hour_in = (hh == 8'h0C ? 8'h00 : hh) + (b[7] ? 8'h0C : 8'h00);
    end
    else
    begin
      hour_in = hh;
    end
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m,
    input logic [7:0] y);
    case (m)
      8'h02: month_len = (y[1:0] == 2'b00) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: month_len = 8'h1E;
      default: month_len = 8'h1F;
    endcase
  endfunction

  function automatic rtc_pkg::rtc_time_type advance(
    input rtc_pkg::rtc_time_type t);
    rtc_pkg::rtc_time_type n;
    n = t;
    n.sec = t.sec + 8'h01;
    if (n.sec >= 8'h3C)
    begin
      n.sec = 8'h00;
      n.min = t.min + 8'h01;
      if (n.min >= 8'h3C)
      begin
        n.min = 8'h00;
        n.hour = t.hour + 8'h01;
        if (n.hour >= 8'h18)
        begin
          n.hour = 8'h00;
          n.wday = (t.wday >= 8'h07) ? 8'h01 : t.wday + 8'h01;
          n.mday = t.mday + 8'h01;
          if (t.mday >= month_len(t.mon, t.year))
          begin
            n.mday = 8'h01;
            n.mon = t.mon + 8'h01;
            if (t.mon >= 8'h0C)
            begin
              n.mon = 8'h01;
              n.year = (t.year >= 8'h63) ? 8'h00 : t.year + 8'h01;
            end
          end
        end
      end
    end
    advance = n;
  endfunction

  function automatic rtc_pkg::rtc_state_type reset_state();
    rtc_pkg::rtc_state_type s;
    s = '0;
    s.st = rtc_pkg::I2C_IDLE;
    s.tm.hour = `RTC_R_HOUR;
    s.tm.wday = `RTC_R_WDAY;
    s.tm.mday = `RTC_R_MDAY;
    s.tm.mon = `RTC_R_MON;
    s.snap = s.tm;
    s.stamp = s.tm;
    s.alm_hour = `RTC_R_HOUR;
    s.osc = `RTC_R_OSC;
    s.lfsr = 16'hACE1;
    s.scl_p = 1'b1;
    s.sda_p = 1'b1;
    reset_state = s;
  endfunction

  localparam rtc_pkg::rtc_state_type RESET_STATE = reset_state();

  rtc_pkg::rtc_state_type q_q;
  rtc_pkg::rtc_state_type q_d;
  logic [7:0] rd_val;
  logic bin;
  logic h12;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign bin = q_q.ctrl[`RTC_B_BINARY];
  assign h12 = q_q.ctrl[`RTC_B_H12];
  assign scl_rise = scl_in & ~q_q.scl_p;
  assign scl_fall = ~scl_in & q_q.scl_p;
  assign bus_start = scl_in & q_q.scl_p & q_q.sda_p & ~sda_in;
  assign bus_stop = scl_in & q_q.scl_p & ~q_q.sda_p & sda_in;

  // Time reads come from the snapshot taken at address match
  always_comb
  begin
    case (q_q.ptr)
      `RTC_A_SEC: rd_val = enc(q_q.snap.sec, bin);
      `RTC_A_SALM: rd_val = enc(q_q.alm_sec, bin);
      `RTC_A_MIN: rd_val = enc(q_q.snap.min, bin);
      `RTC_A_MALM: rd_val = enc(q_q.alm_min, bin);
      `RTC_A_HOUR: rd_val = hour_out(q_q.snap.hour, bin, h12);
      `RTC_A_HALM: rd_val = hour_out(q_q.alm_hour, bin, h12);
      `RTC_A_WDAY: rd_val = q_q.snap.wday;
      `RTC_A_MDAY: rd_val = enc(q_q.snap.mday, bin);
      `RTC_A_MON: rd_val = enc(q_q.snap.mon, bin);
      `RTC_A_YEAR: rd_val = enc(q_q.snap.year, bin);
      `RTC_A_CTRL: rd_val = q_q.ctrl;
      `RTC_A_STAT: rd_val = {q_q.alarm_flag, q_q.osc_fail_flag,
        q_q.clock_flag, q_q.clock_irq_flag, 1'b0, battery_level};
      `RTC_A_CLKO: rd_val = q_q.clkctl;
      `RTC_A_CTRL2: rd_val = q_q.ctrl2;
      `RTC_A_SCR: rd_val = q_q.scratch;
      `RTC_A_REV: rd_val = REVISION;
      `RTC_A_MAKER: rd_val = MAKER;
      `RTC_A_PART: rd_val = PART;
      `RTC_A_TRIM: rd_val = q_q.trim;
      `RTC_A_OSC: rd_val = q_q.osc;
      `RTC_A_SRC: rd_val = q_q.srccfg;
      `RTC_A_TS_SEC: rd_val = enc(q_q.stamp.sec, bin);
      `RTC_A_TS_MIN: rd_val = enc(q_q.stamp.min, bin);
      `RTC_A_TS_HOUR: rd_val = hour_out(q_q.stamp.hour, bin, h12);
      `RTC_A_TS_WDAY: rd_val = q_q.stamp.wday;
      `RTC_A_TS_MDAY: rd_val = enc(q_q.stamp.mday, bin);
      `RTC_A_TS_MON: rd_val = enc(q_q.stamp.mon, bin);
      `RTC_A_TS_YEAR: rd_val = enc(q_q.stamp.year, bin);
      `RTC_A_RND1: rd_val = q_q.rnd1;
      `RTC_A_RND2: rd_val = q_q.rnd2;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb
  begin
    logic wr;
    logic sec_tick;
    logic hit;
    logic [7:0] wd;
    logic [1:0] sel;
    rtc_pkg::rtc_time_type nt;
    q_d = q_q;
    wr = 1'b0;
    hit = 1'b0;
    wd = q_q.shreg;
    nt = advance(q_q.tm);
    sec_tick = tick_32k & ~q_q.ctrl[`RTC_B_STOP] & (q_q.presc == PRESC_LAST);
    sel = q_q.clkctl[1:0];
    q_d.scl_p = scl_in;
    q_d.sda_p = sda_in;
    if (bus_stop)
    begin
      q_d.st = rtc_pkg::I2C_IDLE;
      q_d.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      q_d.st = rtc_pkg::I2C_ADDR;
      q_d.bitc = 4'h0;
      q_d.sda_oe = 1'b0;
    end
    else
    begin
      unique case (q_q.st)
        rtc_pkg::I2C_IDLE:
        begin
          q_d.sda_oe = 1'b0;
        end
        rtc_pkg::I2C_ADDR, rtc_pkg::I2C_PTR, rtc_pkg::I2C_WR:
        begin
          if (scl_rise)
          begin
            q_d.shreg = {q_q.shreg[6:0], sda_in};
            q_d.bitc = q_q.bitc + 4'h1;
          end
          else if (scl_fall && q_q.bitc == 4'h8)
          begin
            q_d.sda_oe = 1'b1;
            if (q_q.st == rtc_pkg::I2C_ADDR)
            begin
              if (q_q.shreg[7:1] == `RTC_I2C_ADDR)
              begin
                q_d.rw = q_q.shreg[0];
                q_d.snap = q_q.tm;
                q_d.st = rtc_pkg::I2C_ACK_A;
              end
              else
              begin
                q_d.sda_oe = 1'b0;
                q_d.st = rtc_pkg::I2C_IDLE;
              end
            end
            else if (q_q.st == rtc_pkg::I2C_PTR)
            begin
              q_d.ptr = q_q.shreg;
              q_d.st = rtc_pkg::I2C_ACK_P;
            end
            else
            begin
              wr = 1'b1;
              q_d.ptr = q_q.ptr + 8'h01;
              q_d.st = rtc_pkg::I2C_ACK_W;
            end
          end
        end
        rtc_pkg::I2C_ACK_A, rtc_pkg::I2C_ACK_P, rtc_pkg::I2C_ACK_W:
        begin
          if (scl_fall)
          begin
            q_d.bitc = 4'h0;
            q_d.sda_oe = 1'b0;
            if (q_q.st == rtc_pkg::I2C_ACK_A && q_q.rw)
            begin
              q_d.shreg = rd_val;
              q_d.sda_oe = ~rd_val[7];
              q_d.st = rtc_pkg::I2C_RD;
            end
            else if (q_q.st == rtc_pkg::I2C_ACK_A)
            begin
              q_d.st = rtc_pkg::I2C_PTR;
            end
            else
            begin
              q_d.st = rtc_pkg::I2C_WR;
            end
          end
        end
        rtc_pkg::I2C_RD:
        begin
          if (scl_fall && q_q.bitc == 4'h7)
          begin
            q_d.sda_oe = 1'b0;
            q_d.ptr = q_q.ptr + 8'h01;
            q_d.st = rtc_pkg::I2C_ACK_R;
          end
          else if (scl_fall)
          begin
            q_d.bitc = q_q.bitc + 4'h1;
            q_d.shreg = {q_q.shreg[6:0], 1'b0};
            q_d.sda_oe = ~q_q.shreg[6];
          end
        end
        rtc_pkg::I2C_ACK_R:
        begin
          // A not-acknowledge ends the read; wait for stop
          if (scl_rise && sda_in)
          begin
            q_d.st = rtc_pkg::I2C_IDLE;
          end
          else if (scl_fall)
          begin
            q_d.bitc = 4'h0;
            q_d.shreg = rd_val;
            q_d.sda_oe = ~rd_val[7];
            q_d.st = rtc_pkg::I2C_RD;
          end
        end
        default:
        begin
          q_d.st = rtc_pkg::I2C_IDLE;
          q_d.sda_oe = 1'b0;
        end
      endcase
    end

    q_d.lfsr = {q_q.lfsr[14:0],
      q_q.lfsr[15] ^ q_q.lfsr[13] ^ q_q.lfsr[12] ^ q_q.lfsr[10]};
    if (tick_32k && !q_q.ctrl[`RTC_B_STOP])
    begin
      q_d.presc = sec_tick ? 15'h0000 : q_q.presc + 15'h0001;
    end
    if (sec_tick)
    begin
      q_d.tm = nt;
      hit = (nt.sec == q_q.alm_sec) && (nt.min == q_q.alm_min) &&
        (nt.hour == q_q.alm_hour);
    end
    if (hit)
    begin
      q_d.stamp = nt;
      q_d.rnd1 = q_q.lfsr[7:0];
      q_d.rnd2 = q_q.lfsr[15:8];
    end

    // Writing zero clears a flag, but a new event in that cycle wins
    if (wr && q_q.ptr == `RTC_A_STAT)
    begin
      q_d.alarm_flag = q_q.alarm_flag & wd[7];
      q_d.osc_fail_flag = q_q.osc_fail_flag & wd[6];
      q_d.clock_flag = q_q.clock_flag & wd[5];
      q_d.clock_irq_flag = q_q.clock_irq_flag & wd[4];
    end
    q_d.alarm_flag = q_d.alarm_flag | hit;
    q_d.osc_fail_flag = q_d.osc_fail_flag | osc_fail;
    q_d.clock_flag = q_d.clock_flag | sec_tick;
    q_d.clock_irq_flag = q_d.clock_irq_flag |
      (sec_tick & q_q.ctrl[`RTC_B_CLK_EN]);

    // A host write lands after the tick so the written value sticks
    if (wr)
    begin
      case (q_q.ptr)
        `RTC_A_SEC:
        begin
          q_d.tm.sec = dec({1'b0, wd[6:0]}, bin);
          q_d.presc = 15'h0000;
        end
        `RTC_A_SALM: q_d.alm_sec = dec({1'b0, wd[6:0]}, bin);
        `RTC_A_MIN: q_d.tm.min = dec({1'b0, wd[6:0]}, bin);
        `RTC_A_MALM: q_d.alm_min = dec({1'b0, wd[6:0]}, bin);
        `RTC_A_HOUR: q_d.tm.hour = hour_in(wd, bin, h12);
        `RTC_A_HALM: q_d.alm_hour = hour_in(wd, bin, h12);
        `RTC_A_WDAY: q_d.tm.wday = {5'h00, wd[2:0]};
        `RTC_A_MDAY: q_d.tm.mday = dec({2'b00, wd[5:0]}, bin);
        `RTC_A_MON: q_d.tm.mon = dec({3'b000, wd[4:0]}, bin);
        `RTC_A_YEAR: q_d.tm.year = dec(wd, bin);
        `RTC_A_CTRL: q_d.ctrl = wd;
        `RTC_A_CLKO: q_d.clkctl = wd & `RTC_M_CLKO;
        `RTC_A_CTRL2: q_d.ctrl2 = wd & `RTC_M_CTRL2;
        `RTC_A_SCR: q_d.scratch = wd;
        `RTC_A_TRIM: q_d.trim = wd;
        `RTC_A_OSC: q_d.osc = wd & `RTC_M_OSC;
        `RTC_A_SRC: q_d.srccfg = wd & `RTC_M_SRC;
        default: q_d.ctrl2 = q_d.ctrl2;
      endcase
    end

    q_d.alert = (q_d.alarm_flag & q_d.ctrl[`RTC_B_AL_EN]) |
      (q_d.osc_fail_flag & q_d.ctrl[`RTC_B_OSCF_EN]) |
      (q_d.clock_irq_flag & q_d.ctrl[`RTC_B_CLK_EN]);
    // Divider taps give 16384, 1024, 32 and 1 Hz from the tick
    q_d.clkpin = q_q.clkctl[7] & (q_q.osc[7] ^
      (sel == 2'b00 ? q_q.presc[0] : sel == 2'b01 ? q_q.presc[4] :
       sel == 2'b10 ? q_q.presc[9] : q_q.presc[14]));
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q_q <= RESET_STATE;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q_q.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe = q_q.alert;
  assign clock_output_pin = q_q.clkpin;
endmodule // rtc_top

/* File: testbench/rtc_checker.sv */
// Port-level assertions of the clock calendar register bank
`timescale 1ns/1ns
module rtc_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick_32k,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic osc_fail,
  input wire logic [2:0] battery_level,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic clock_output_pin
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_reset_quiet;
    $past(rst) |-> !sda_oe && !alert_oe && !clock_output_pin;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");

  property p_sda_open_drain;
    sda_out == 1'b0;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain)
    else $error("data line driven high");

  property p_alert_open_drain;
    alert_out == 1'b0;
  endproperty
  a_alert_open_drain: assert property (p_alert_open_drain)
    else $error("alert line driven high");

  // The device may only move SDA just after SCL has fallen
  property p_drive_after_fall;
    $rose(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("data drive not one cycle after clock fall");

  property p_release_after_fall;
    $fell(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2);
  endproperty
  a_release_after_fall: assert property (p_release_after_fall)
    else $error("data release not one cycle after clock fall");

  // A change while SCL is high would look like a start or stop
  property p_hold_while_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_hold_while_high: assert property (p_hold_while_high)
    else $error("data drive changed while clock high");

  property p_drive_held;
    $rose(sda_oe) |=> sda_oe [*4];
  endproperty
  a_drive_held: assert property (p_drive_held)
    else $error("data drive dropped before next clock fall");

  property p_clk_pin_cause;
    $changed(clock_output_pin) |->
      $past(tick_32k) || $past(tick_32k, 2) || !$past(scl_in);
  endproperty
  a_clk_pin_cause: assert property (p_clk_pin_cause)
    else $error("clock output moved without tick or write");
endmodule // rtc_checker

bind rtc_top rtc_checker chk_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .tick_32k(tick_32k),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .osc_fail(osc_fail),
  .battery_level(battery_level),
  .alert_out(alert_out),
  .alert_oe(alert_oe),
  .clock_output_pin(clock_output_pin)
);

/* File: testbench/rtc_host.sv */
// I2C controller model standing in for the host processor
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_host (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  logic [7:0] wbuf [0:9];
  logic [7:0] rbuf [0:31];
  logic ack;
  logic r;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Four cycles per phase keeps SCL low and high above three cycles
  task automatic phase();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda = b;
    phase();
    scl = 1'b1;
    phase();
    s = sda_wire;
    scl = 1'b0;
    phase();
  endtask
  task automatic start();
    sda = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda = 1'b0;
    phase();
    scl = 1'b0;
    phase();
  endtask
  task automatic stop();
    sda = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda = 1'b1;
    phase();
  endtask
  task automatic send(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic probe(input logic [6:0] dev);
    start();
    send({dev, 1'b0});
    stop();
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    start();
    send({`RTC_I2C_ADDR, 1'b0});
    send(a);
    for (int i = 0; i < n; i++)
      send(wbuf[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d;
    start();
    send({`RTC_I2C_ADDR, 1'b0});
    send(a);
    start();
    send({`RTC_I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++)
    begin
      for (int j = 7; j >= 0; j--)
        bit_io(1'b1, d[j]);
      bit_io(i == n - 1, r);
      rbuf[i] = d;
    end
    stop();
  endtask
endmodule // rtc_host

/* File: testbench/testbench.sv */
// Self-checking bench of the clock calendar register bank
`timescale 1ns/1ns
`include "rtc_params.svh"
module testbench;
  localparam logic [7:0] REV = 8'h34; // arbitrary
  localparam logic [7:0] MKR = 8'h6B; // arbitrary
  localparam logic [7:0] PRT = 8'h29; // arbitrary
  // Address, written value, value read back
  localparam logic [23:0] ROWS [0:15] = '{
    24'h0EA5A5, 24'h0CFF83, 24'h0DFF01, 24'h13FFDF,
    24'h14FF80, 24'h125A5A, {16'h0F00, REV}, {16'h1000, MKR},
    {16'h1100, PRT}, 24'h1EFF00, 24'hFFFF00, 24'h015959,
    24'h033737, 24'h052323, 24'h153300, 24'h1C7700};
  localparam logic [7:0] RSTV [0:29] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h12, 8'h07, 8'h01, 8'h01, 8'h00,
    8'h00, 8'h05, 8'h00, 8'h00, 8'h00, REV, MKR, PRT, 8'h00, 8'h02,
    8'h00, 8'h00, 8'h00, 8'h12, 8'h07, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  // Control value, seconds, hours, hours alarm for 45 s and 23 h
  localparam logic [31:0] MODES [0:3] = '{
    32'h00452323, 32'h402D1717, 32'h20459191, 32'h602D8B8B};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tick_32k = 1'b0;
  logic osc_fail = 1'b0;
  logic [2:0] battery_level = 3'h5;
  logic scl, sda_host, sda_wire, sda_out, sda_oe;
  logic alert_out, alert_oe, clock_output_pin;
  logic [7:0] e [0:9];
  int fails = 0;
  int compares = 0;
  always #2 clk_sys = ~clk_sys;
  // Pulled-up wire: low when either party pulls it
  assign sda_wire = sda_host & ~sda_oe;
  rtc_top #(.TICKS_PER_SEC(4), .REVISION(REV), .MAKER(MKR), .PART(PRT)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_32k(tick_32k),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .osc_fail(osc_fail),
    .battery_level(battery_level),
    .alert_out(alert_out),
    .alert_oe(alert_oe),
    .clock_output_pin(clock_output_pin)
  );
  rtc_host host (
    .clk_sys(clk_sys),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda(sda_host)
  );
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      tick_32k = 1'b1;
      @(negedge clk_sys);
      tick_32k = 1'b0;
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wbuf[0] = d;
    host.wr(a, 1);
  endtask
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    host.probe(7'h50);
    chk("foreign ack", 8'h00, {7'h00, host.ack});
    host.probe(`RTC_I2C_ADDR);
    chk("own ack", 8'h01, {7'h00, host.ack});
    foreach (ROWS[i])
    begin
      put(ROWS[i][23:16], ROWS[i][15:8]);
      host.rd(ROWS[i][23:16], 1);
      chk("reg", ROWS[i][7:0], host.rbuf[0]);
    end
    // Output enabled and inverted while the slowest tap is still low
    chk("clock pin", 8'h01, {7'h00, clock_output_pin});
    put(`RTC_A_SEC, 8'h45);
    put(`RTC_A_HOUR, 8'h23);
    foreach (MODES[i])
    begin
      put(`RTC_A_CTRL, MODES[i][31:24]);
      host.rd(`RTC_A_SEC, 6);
      chk("seconds", MODES[i][23:16], host.rbuf[0]);
      chk("hours", MODES[i][15:8], host.rbuf[4]);
      chk("hours alarm", MODES[i][7:0], host.rbuf[5]);
    end
    for (int y = 4; y < 6; y++)
    begin
      put(`RTC_A_CTRL, 8'h0A);
      host.wbuf = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07,
                    8'h28, 8'h02, y[7:0]};
      host.wr(`RTC_A_SEC, 10);
      ticks(4);
      e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
            (y == 4) ? 8'h29 : 8'h01, (y == 4) ? 8'h02 : 8'h03, y[7:0]};
      host.rd(`RTC_A_SEC, 10);
      for (int i = 0; i < 10; i++)
        chk("rollover", e[i], host.rbuf[i]);
      chk("alarm pin", 8'h01, {7'h00, alert_oe});
      host.rd(`RTC_A_TS_SEC, 7);
      for (int i = 0; i < 7; i++)
        chk("stamp", e[i < 3 ? 2 * i : i + 3], host.rbuf[i]);
      host.rd(`RTC_A_STAT, 1);
      chk("status", 8'hB5, host.rbuf[0]);
      put(`RTC_A_STAT, 8'h00);
      chk("alarm pin clear", 8'h00, {7'h00, alert_oe});
    end
    put(`RTC_A_CTRL, 8'h04);
    @(negedge clk_sys);
    osc_fail = 1'b1;
    @(negedge clk_sys);
    osc_fail = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("osc fail pin", 8'h01, {7'h00, alert_oe});
    host.rd(`RTC_A_STAT, 1);
    chk("osc fail flag", 8'h45, host.rbuf[0]);
    host.wbuf[0] = 8'h3C;
    host.wbuf[1] = 8'h3C;
    host.wbuf[2] = 8'h30;
    host.wr(8'hFE, 3);
    host.rd(8'hFF, 2);
    chk("top address", 8'h00, host.rbuf[0]);
    chk("wrapped", 8'h30, host.rbuf[1]);
    put(`RTC_A_CTRL, 8'h80);
    ticks(4);
    host.rd(`RTC_A_SEC, 1);
    chk("stopped", 8'h30, host.rbuf[0]);
    put(`RTC_A_CTRL, 8'h00);
    ticks(4);
    host.rd(`RTC_A_SEC, 1);
    chk("running", 8'h31, host.rbuf[0]);
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    host.rd(8'h00, 30);
    for (int i = 0; i < 30; i++)
      chk("reset value", RSTV[i], host.rbuf[i]);
    conclude();
  end
endmodule // testbench
